// ---- rtl/odg_top.sv ----
`timescale 1ns/10ps
`include "odg_defs.svh"
module odg_top #(
    parameter int ON_CYCLES = `ODG_T_ON_MS * `ODG_CLK_KHZ
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic byte_valid,
    input wire logic byte_dc,
    input wire logic [7:0] byte_data,
    output logic [7:0] segment_output_idx,
    output logic [5:0] common_output_idx,
    output logic [7:0] drive_pulse_width,
    output logic precharge_en,
    output logic segment_valid,
    output logic row_start,
    output logic outputs_on,
    output logic iref_internal,
    output logic [12:0] segment_current
);
    import odg_pkg::*;

    odg_scan_if sif ();

    // ----------------------------------------
    // Configuration state
    // ----------------------------------------
    odg_cmd_state_e state_q, state_d;
    logic [7:0] cmd_q;
    logic [3:0] pidx_q;
    logic [6:0] col_start_q, col_end_q, col_q;
    logic [5:0] row_start_q, row_end_q, row_q;
    logic [7:0] contrast_q;
    logic [7:0] remap_q;
    logic [5:0] start_line_q;
    logic iref_sel_q;
    logic disp_on_q;
    odg_gray_t gray_q;
    logic [7:0] mem_q [0:8191];
    logic [`ODG_ON_CNT_W-1:0] on_cnt_q;

    // Wrapping step inside a window; shared by column and row pointers
    function automatic logic [7:0] odg_step(input logic [6:0] cur, input logic [6:0] lo,
            input logic [6:0] hi);
        odg_step = (cur == hi) ? {1'b1, lo} : {1'b0, cur + 7'h01};
    endfunction

    // ----------------------------------------
    // Byte decode
    // ----------------------------------------
    logic data_wr, cmd_byte, param_byte, param_last;
    logic [3:0] plast;
    logic vert;
    logic [7:0] col_step, row_step;
    logic [6:0] col_next;
    logic [5:0] row_next;

    assign data_wr = byte_valid && byte_dc;
    assign cmd_byte = byte_valid && !byte_dc && state_q == ODG_IDLE;
    assign param_byte = byte_valid && !byte_dc && state_q == ODG_PARAM;
    assign plast = (cmd_q == `ODG_CMD_GRAY_TABLE) ? `ODG_GRAY_LAST_IDX
        : ((cmd_q == `ODG_CMD_COL_ADDR || cmd_q == `ODG_CMD_ROW_ADDR) ? 4'h1 : 4'h0);
    assign param_last = param_byte && pidx_q == plast;
    assign vert = remap_q[`ODG_REMAP_VERT_BIT];
    assign col_step = odg_step(col_q, col_start_q, col_end_q);
    assign row_step = odg_step({1'b0, row_q}, {1'b0, row_start_q}, {1'b0, row_end_q});
    // Horizontal: column first, row on column wrap; vertical the reverse
    assign col_next = (!vert || row_step[7]) ? col_step[6:0] : col_q;
    assign row_next = (vert || col_step[7]) ? row_step[5:0] : row_q;

    always_comb begin
        state_d = state_q;
        if (cmd_byte) begin
            case (byte_data)
                `ODG_CMD_COL_ADDR, `ODG_CMD_ROW_ADDR, `ODG_CMD_CONTRAST, `ODG_CMD_REMAP,
                `ODG_CMD_START_LINE, `ODG_CMD_IREF_SEL, `ODG_CMD_GRAY_TABLE: begin
                    state_d = ODG_PARAM;
                end
                default: begin
                    state_d = ODG_IDLE;
                end
            endcase
        end else if (param_last) begin
            state_d = ODG_IDLE;
        end
    end

    // Command sequencer
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q <= ODG_IDLE;
            cmd_q <= 8'h00;
            pidx_q <= 4'h0;
        end else begin
            state_q <= state_d;
            if (cmd_byte) begin
                cmd_q <= byte_data;
            end
            pidx_q <= cmd_byte ? 4'h0 : (param_byte ? pidx_q + 4'h1 : pidx_q);
        end
    end

    // Settings taken from command parameters; display on/off taken from its own command byte
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            col_start_q <= 7'h00;
            col_end_q <= `ODG_COL_END_RST;
            row_start_q <= 6'h00;
            row_end_q <= `ODG_ROW_END_RST;
            contrast_q <= `ODG_CONTRAST_RST;
            remap_q <= 8'h00;
            start_line_q <= 6'h00;
            iref_sel_q <= 1'b0;
            disp_on_q <= 1'b0;
        end else begin
            if (cmd_byte && byte_data == `ODG_CMD_DISP_ON) begin
                disp_on_q <= 1'b1;
            end else if (cmd_byte && byte_data == `ODG_CMD_DISP_OFF) begin
                disp_on_q <= 1'b0;
            end
            if (param_byte) begin
                case (cmd_q)
                    `ODG_CMD_COL_ADDR: begin
                        if (pidx_q == 4'h0) begin
                            col_start_q <= byte_data[6:0];
                        end else begin
                            col_end_q <= byte_data[6:0];
                        end
                    end
                    `ODG_CMD_ROW_ADDR: begin
                        if (pidx_q == 4'h0) begin
                            row_start_q <= byte_data[5:0];
                        end else begin
                            row_end_q <= byte_data[5:0];
                        end
                    end
                    `ODG_CMD_CONTRAST: contrast_q <= byte_data;
                    `ODG_CMD_REMAP: remap_q <= byte_data;
                    `ODG_CMD_START_LINE: start_line_q <= byte_data[5:0];
                    `ODG_CMD_IREF_SEL: iref_sel_q <= byte_data[`ODG_IREF_BIT];
                    default: begin
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // Write pointer and display memory
    // ----------------------------------------
    // Setting a window parks the pointer on its start corner
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            col_q <= 7'h00;
            row_q <= 6'h00;
        end else if (param_byte && cmd_q == `ODG_CMD_COL_ADDR && pidx_q == 4'h0) begin
            col_q <= byte_data[6:0];
        end else if (param_byte && cmd_q == `ODG_CMD_ROW_ADDR && pidx_q == 4'h0) begin
            row_q <= byte_data[5:0];
        end else if (data_wr) begin
            col_q <= col_next;
            row_q <= row_next;
        end
    end

    // Physical address only; remap never rewrites storage
    always_ff @(posedge sys_clk) begin
        if (data_wr) begin
            mem_q[{row_q, col_q}] <= byte_data;
        end
    end

    // ----------------------------------------
    // Gray scale table
    // ----------------------------------------
    // Level 0 is only ever loaded with zero, so it stays dark
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int i = 0; i < 16; i++) begin
                gray_q[i] <= 8'(i * 12);
            end
        end else if (cmd_byte && byte_data == `ODG_CMD_GRAY_LINEAR) begin
            for (int i = 0; i < 16; i++) begin
                gray_q[i] <= 8'(i) * `ODG_LINEAR_STEP;
            end
        end else if (param_byte && cmd_q == `ODG_CMD_GRAY_TABLE) begin
            gray_q[pidx_q + 4'h1] <= byte_data;
        end
    end

    // ----------------------------------------
    // Power-on delay and analog settings
    // ----------------------------------------
    // Long delay counter; shorten ON_CYCLES in simulation
    always_ff @(posedge sys_clk) begin
        if (!resetn || !disp_on_q) begin
            on_cnt_q <= '0;
            outputs_on <= 1'b0;
        end else if (on_cnt_q == `ODG_ON_CNT_W'(ON_CYCLES - 1)) begin
            outputs_on <= 1'b1;
        end else begin
            on_cnt_q <= on_cnt_q + `ODG_ON_CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            iref_internal <= 1'b0;
            segment_current <= 13'h0000;
        end else begin
            iref_internal <= iref_sel_q && disp_on_q;
            segment_current <= {contrast_q, 5'h00};
        end
    end

    // ----------------------------------------
    // Scan engine
    // ----------------------------------------
    assign sif.mem_data = mem_q[sif.mem_addr];
    assign sif.col_remap = remap_q[`ODG_REMAP_COL_BIT];
    assign sif.nib_remap = remap_q[`ODG_REMAP_NIB_BIT];
    assign sif.com_remap = remap_q[`ODG_REMAP_COM_BIT];
    assign sif.start_line = start_line_q;
    assign sif.gray_tab = gray_q;
    assign segment_output_idx = sif.seg_idx;
    assign common_output_idx = sif.com_idx;
    assign drive_pulse_width = sif.drive_w;
    assign precharge_en = sif.precharge_en;
    assign segment_valid = sif.seg_valid;
    assign row_start = sif.row_start;

    odg_scan odg_scan_inst (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .sif(sif)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_data_mid_row;
        data_wr && !vert && col_q != col_end_q;
    endsequence
    sequence s_data_last_cell;
        data_wr && col_q == col_end_q && row_q == row_end_q;
    endsequence

    AST_DATA_STORED: assert property (
        data_wr |=> mem_q[$past({row_q, col_q})] == $past(byte_data))
        else $error("Data byte not stored");
    AST_COL_ADVANCE: assert property (
        s_data_mid_row |=> col_q == $past(col_q) + 7'h01 && row_q == $past(row_q))
        else $error("Column pointer did not advance");
    AST_VERT_ADVANCE: assert property (
        data_wr && vert && row_q != row_end_q |=> row_q == $past(row_q) + 6'h01
            && $stable(col_q))
        else $error("Vertical increment wrong");
    AST_WINDOW_WRAP: assert property (
        s_data_last_cell |=> col_q == col_start_q && row_q == row_start_q)
        else $error("Pointer did not wrap to window start");
    AST_LINEAR: assert property (
        cmd_byte && byte_data == `ODG_CMD_GRAY_LINEAR |=> gray_q[15] == 8'hB4
            && gray_q[1] == 8'h0C && gray_q[0] == 8'h00)
        else $error("Linear table wrong");
    AST_ON_DELAY: assert property (
        $rose(outputs_on) |-> $past(on_cnt_q) == `ODG_ON_CNT_W'(ON_CYCLES - 1)
            && disp_on_q)
        else $error("Outputs on at wrong time");
    AST_IREF: assert property (
        ##1 iref_internal |-> $past(iref_sel_q) && $past(disp_on_q, 1))
        else $error("Internal reference without display on");
    AST_CONTRAST: assert property (
        param_byte && cmd_q == `ODG_CMD_CONTRAST |=> ##1
            segment_current == {$past(byte_data, 2), 5'h00})
        else $error("Segment current not contrast times 32");
endmodule

// ---- rtl/odg_defs.svh ----
`ifndef ODG_DEFS_SVH
`define ODG_DEFS_SVH

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define ODG_CMD_COL_ADDR 8'h15
`define ODG_CMD_ROW_ADDR 8'h75
`define ODG_CMD_CONTRAST 8'h81
`define ODG_CMD_REMAP 8'hA0
`define ODG_CMD_START_LINE 8'hA1
`define ODG_CMD_IREF_SEL 8'hAD
`define ODG_CMD_DISP_OFF 8'hAE
`define ODG_CMD_DISP_ON 8'hAF
`define ODG_CMD_GRAY_TABLE 8'hB8
`define ODG_CMD_GRAY_LINEAR 8'hB9

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ODG_REMAP_COL_BIT 0
`define ODG_REMAP_NIB_BIT 1
`define ODG_REMAP_VERT_BIT 2
`define ODG_REMAP_COM_BIT 4
`define ODG_IREF_BIT 4

// ----------------------------------------
// Reset values and geometry
// ----------------------------------------
`define ODG_COL_END_RST 7'h7F
`define ODG_ROW_END_RST 6'h3F
`define ODG_CONTRAST_RST 8'h7F
`define ODG_LINEAR_STEP 8'h0C
`define ODG_GRAY_LAST_IDX 4'hE
`define ODG_SEG_LAST 8'hFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define ODG_CLK_KHZ 20000
`define ODG_T_ON_MS 200
`define ODG_ON_CNT_W 23
`define ODG_DISP_DIV 4'h2
`define ODG_PHASE1_TICKS 9'h004
`define ODG_PHASE2_TICKS 9'h010
`define ODG_ROW_EXTRA_TICKS 9'h00F

`endif

// ---- rtl/odg_pkg.sv ----
package odg_pkg;
    typedef logic [15:0][7:0] odg_gray_t;
    typedef enum logic [0:0] {
        ODG_IDLE,
        ODG_PARAM
    } odg_cmd_state_e;
endpackage

// ---- rtl/odg_scan_if.sv ----
`timescale 1ns/10ps
interface odg_scan_if;
    import odg_pkg::*;
    logic [12:0] mem_addr;
    logic [7:0] mem_data;
    logic col_remap;
    logic nib_remap;
    logic com_remap;
    logic [5:0] start_line;
    odg_gray_t gray_tab;
    logic [7:0] seg_idx;
    logic [5:0] com_idx;
    logic [7:0] drive_w;
    logic precharge_en;
    logic seg_valid;
    logic row_start;

    modport top (
        output mem_data, col_remap, nib_remap, com_remap, start_line, gray_tab,
        input mem_addr, seg_idx, com_idx, drive_w, precharge_en, seg_valid, row_start
    );
    modport scan (
        input mem_data, col_remap, nib_remap, com_remap, start_line, gray_tab,
        output mem_addr, seg_idx, com_idx, drive_w, precharge_en, seg_valid, row_start
    );
endinterface

// ---- rtl/odg_scan.sv ----
`timescale 1ns/10ps
`include "odg_defs.svh"
module odg_scan (
    input wire logic sys_clk,
    input wire logic resetn,
    odg_scan_if.scan sif
);
    import odg_pkg::*;

    // ----------------------------------------
    // Display clock and row timing
    // ----------------------------------------
    logic [3:0] div_q, div_d;
    logic [8:0] row_cnt_q, row_cnt_d;
    logic [7:0] seg_q, seg_d;
    logic [5:0] com_q, com_d;
    logic sweep_q, sweep_d;
    logic disp_tick;
    logic [8:0] row_len;
    logic row_end;

    // Row length follows the brightest entry, so frame rate moves with it
    assign row_len = `ODG_PHASE1_TICKS + `ODG_PHASE2_TICKS + {1'b0, sif.gray_tab[15]}
        + `ODG_ROW_EXTRA_TICKS;
    assign disp_tick = (div_q == `ODG_DISP_DIV - 4'h1);
    // Short rows still wait for the segment sweep to finish
    assign row_end = disp_tick && (row_cnt_q >= row_len - 9'h001) && !sweep_q;
    assign div_d = disp_tick ? 4'h0 : div_q + 4'h1;
    assign row_cnt_d = row_end ? 9'h000 : (disp_tick ? row_cnt_q + 9'h001 : row_cnt_q);
    assign com_d = row_end ? com_q + 6'h01 : com_q;
    assign sweep_d = row_end ? 1'b1 : (sweep_q && seg_q != `ODG_SEG_LAST);
    assign seg_d = row_end ? 8'h00 : (sweep_q ? seg_q + 8'h01 : seg_q);

    // ----------------------------------------
    // Memory address mapping
    // ----------------------------------------
    logic [5:0] mem_row;
    logic [6:0] mem_col;
    logic nib_hi;
    logic [3:0] code;

    // Start line rotates rows; common reversal runs them downward
    assign mem_row = sif.com_remap ? sif.start_line - 6'h01 - com_q
        : com_q + sif.start_line;
    assign mem_col = sif.col_remap ? ~seg_q[7:1] : seg_q[7:1];
    assign nib_hi = seg_q[0] ^ sif.nib_remap;
    assign sif.mem_addr = {mem_row, mem_col};
    assign code = nib_hi ? sif.mem_data[7:4] : sif.mem_data[3:0];

    // Counters advance on every clock; the display tick paces the row only
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            div_q <= 4'h0;
            row_cnt_q <= 9'h000;
            seg_q <= 8'h00;
            com_q <= 6'h00;
            sweep_q <= 1'b1;
        end else begin
            div_q <= div_d;
            row_cnt_q <= row_cnt_d;
            seg_q <= seg_d;
            com_q <= com_d;
            sweep_q <= sweep_d;
        end
    end

    // ----------------------------------------
    // Registered drive outputs
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            sif.seg_idx <= 8'h00;
            sif.com_idx <= 6'h00;
            sif.drive_w <= 8'h00;
            sif.precharge_en <= 1'b0;
            sif.seg_valid <= 1'b0;
            sif.row_start <= 1'b0;
        end else begin
            sif.seg_idx <= seg_q;
            sif.com_idx <= com_q;
            sif.drive_w <= (code == 4'h0) ? 8'h00 : sif.gray_tab[code];
            sif.precharge_en <= (code != 4'h0);
            sif.seg_valid <= sweep_q;
            sif.row_start <= row_end;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Independent clock count, so the period check does not reuse row_cnt_q
    logic [9:0] row_clk_q;
    always_ff @(posedge sys_clk) begin
        if (!resetn || row_end) begin
            row_clk_q <= 10'h000;
        end else begin
            row_clk_q <= row_clk_q + 10'h001;
        end
    end

    AST_DARK_LEVEL: assert property (
        sweep_q && code == 4'h0 |=> sif.drive_w == 8'h00 && !sif.precharge_en)
        else $error("Code zero pixel got drive or precharge");
    AST_GRAY_LOOKUP: assert property (
        sweep_q && code != 4'h0 |=> sif.drive_w == $past(sif.gray_tab[code]))
        else $error("Pulse width differs from table entry");
    AST_ROW_LEN: assert property (
        row_end |-> row_clk_q >= {row_len, 1'b0} - 10'h001)
        else $error("Row ended before its period");
    AST_SWEEP: assert property (
        sweep_q && seg_q != `ODG_SEG_LAST |=> seg_q == $past(seg_q) + 8'h01)
        else $error("Segment sweep skipped");
endmodule

// ---- test/odg_host_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Host side: drives reset and the byte port
// ----------------------------------------
module odg_host_model #(
    parameter int RESET_LOW_CYCLES = 6,
    parameter int CMD_WAIT_CYCLES = 4
) (
    input wire logic sys_clk,
    output logic resetn,
    output logic byte_valid,
    output logic byte_dc,
    output logic [7:0] byte_data
);
    // Everything idle and in reset from time zero
    initial begin
        resetn = 1'b0;
        byte_valid = 1'b0;
        byte_dc = 1'b0;
        byte_data = 8'h00;
    end

    // Reset low for a scaled minimum, then a settle wait before commands
    task automatic power_up;
        repeat (RESET_LOW_CYCLES) @(posedge sys_clk);
        #1 resetn = 1'b1;
        repeat (CMD_WAIT_CYCLES) @(posedge sys_clk);
    endtask

    // Mid-run reset with the same low time and settle wait as at power-up
    task automatic reset_again;
        @(posedge sys_clk);
        #1 resetn = 1'b0;
        power_up();
    endtask

    // One byte per edge; valid stays up so bytes can go back to back
    task automatic send(input logic dc, input logic [7:0] d);
        @(posedge sys_clk);
        #1 byte_valid = 1'b1;
        byte_dc = dc;
        byte_data = d;
    endtask

    // Released bus shows the inverse, so a stale byte is never read as good
    task automatic idle(input int n);
        @(posedge sys_clk);
        #1 byte_valid = 1'b0;
        byte_data = ~byte_data;
        repeat (n - 1) @(posedge sys_clk);
    endtask

    // Display off goes out before the panel supply would be removed
    task automatic power_down;
        send(1'b0, 8'hAE);
        idle(1);
    endtask
endmodule

// ---- test/oled_display_ram_grayscale_map_test.sv ----
`timescale 1ns/10ps
module oled_display_ram_grayscale_map_test;
    localparam int ON_CYC = 20;
    logic sys_clk;
    logic resetn;
    logic byte_valid;
    logic byte_dc;
    logic [7:0] byte_data;
    logic [7:0] seg_idx;
    logic [5:0] com_idx;
    logic [7:0] drive_w;
    logic pre_en;
    logic seg_valid;
    logic row_start;
    logic outputs_on;
    logic iref_internal;
    logic [12:0] seg_current;
    int bad_count;
    int samples_checked;
    int step;
    logic cr;
    logic nr;
    logic comr;
    logic [5:0] sl;
    logic [7:0] pix [64][256];
    logic pre [64][256];
    logic [20:0] cells [$];

    odg_top #(.ON_CYCLES(ON_CYC)) odg_top_inst (.sys_clk(sys_clk), .resetn(resetn),
        .byte_valid(byte_valid), .byte_dc(byte_dc), .byte_data(byte_data),
        .segment_output_idx(seg_idx), .common_output_idx(com_idx), .drive_pulse_width(drive_w),
        .precharge_en(pre_en), .segment_valid(seg_valid), .row_start(row_start),
        .outputs_on(outputs_on), .iref_internal(iref_internal), .segment_current(seg_current));
    odg_host_model odg_host_model_inst (.sys_clk(sys_clk), .resetn(resetn),
        .byte_valid(byte_valid), .byte_dc(byte_dc), .byte_data(byte_data));

    // ----------------------------------------
    // Clock and scan capture
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Keeps the last drive sample of every dot, refreshed each frame
    always @(posedge sys_clk) begin
        if (seg_valid === 1'b1) begin
            pix[com_idx][seg_idx] <= drive_w;
            pre[com_idx][seg_idx] <= pre_en;
        end
    end

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] d);
        odg_host_model_inst.send(1'b0, d);
    endtask
    task automatic dat(input logic [7:0] d);
        odg_host_model_inst.send(1'b1, d);
    endtask
    task automatic cmp_val(input logic [12:0] got, input logic [12:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic hung(input string what);
        bad_count++;
        $display("unexpected at %0t: no progress, %s", $time, what);
        print_verdict();
    endtask
    // A full frame plus margin, so every dot has been redrawn
    task automatic wait_frame;
        int n;
        int t;
        n = 0;
        t = 0;
        while (n < 66) begin
            tick();
            t++;
            if (row_start === 1'b1) n++;
            if (t > 40000) hung("frame");
        end
    endtask
    task automatic row_period(output int p);
        int t;
        t = 0;
        p = 0;
        while (row_start !== 1'b1 && t < 2000) begin tick(); t++; end
        if (t >= 2000) hung("row start");
        tick();
        while (row_start !== 1'b1 && p < 2000) begin tick(); p++; end
        if (p >= 2000) hung("row pulse");
    endtask
    task automatic load_table(input int stp, input logic [7:0] last);
        cmd(8'hB8);
        for (int i = 1; i < 15; i++) cmd(8'(i * stp));
        cmd(last);
        odg_host_model_inst.idle(1);
    endtask
    // Expected placement worked out forward from row, column and remap state
    task automatic check_cells;
        logic [5:0] row;
        logic [5:0] common_output;
        logic [6:0] col;
        logic [6:0] colp;
        logic [7:0] d;
        foreach (cells[i]) begin
            {row, col, d} = cells[i];
            common_output = comr ? sl - 6'd1 - row : row - sl;
            colp = cr ? 7'd127 - col : col;
            cmp_val({5'h0, pix[common_output][{colp, nr}]}, 13'(d[3:0] * step), "low width");
            cmp_val({5'h0, pix[common_output][{colp, ~nr}]}, 13'(d[7:4] * step), "high width");
            cmp_val({12'h0, pre[common_output][{colp, nr}]}, {12'h0, d[3:0] != 0}, "pre");
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        tick();
        tick();
        cmp_val(seg_current, 13'h0FE0, "reset current");
        cmp_val({12'h0, outputs_on}, 13'h0000, "reset on");
        cmp_val({12'h0, iref_internal}, 13'h0000, "reset iref");
    endtask
    task automatic t_contrast;
        logic [7:0] v [2] = '{8'hFF, 8'h01};
        foreach (v[i]) begin
            cmd(8'h81);
            cmd(v[i]);
            odg_host_model_inst.idle(3);
            cmp_val(seg_current, {v[i], 5'h00}, "current");
        end
    endtask
    task automatic t_power;
        int n;
        n = 0;
        cmd(8'hAD);
        cmd(8'h10);
        cmd(8'hAF);
        odg_host_model_inst.idle(1);
        while (outputs_on !== 1'b1 && n < 1000) begin tick(); n++; end
        cmp_val(13'(n >= ON_CYC && n <= ON_CYC + 2), 13'h0001, "on delay");
        tick();
        cmp_val({12'h0, iref_internal}, 13'h0001, "iref on");
        odg_host_model_inst.power_down();
        tick();
        tick();
        cmp_val({12'h0, outputs_on}, 13'h0000, "off");
        cmp_val({12'h0, iref_internal}, 13'h0000, "iref off");
    endtask
    // Slow host fills a 2x2 window; the fifth byte wraps onto the first cell
    task automatic t_window;
        logic [7:0] d [5] = '{8'h21, 8'h43, 8'h65, 8'h87, 8'hF0};
        cmd(8'h15);
        cmd(8'h01);
        cmd(8'h02);
        cmd(8'h75);
        cmd(8'h3E);
        cmd(8'h3F);
        foreach (d[i]) begin
            dat(d[i]);
            odg_host_model_inst.idle(2);
        end
        cells.push_back({6'd62, 7'd1, 8'hF0});
        cells.push_back({6'd62, 7'd2, 8'h43});
        cells.push_back({6'd63, 7'd1, 8'h65});
        cells.push_back({6'd63, 7'd2, 8'h87});
        wait_frame();
        check_cells();
    endtask
    task automatic t_period;
        int p1;
        int p2;
        row_period(p1);
        load_table(5, 8'd200);
        row_period(p2);
        row_period(p2);
        cmp_val(13'(p2 - p1), 13'd40, "row period");
        load_table(5, 8'd75);
        step = 5;
    endtask
    // Back-to-back data in vertical mode with column and nibble swap
    task automatic t_vertical;
        logic [7:0] s [8] = '{8'hA0, 8'h07, 8'h15, 8'h10, 8'h11, 8'h75, 8'h00, 8'h01};
        foreach (s[i]) cmd(s[i]);
        dat(8'h1F);
        dat(8'h2E);
        dat(8'h3D);
        dat(8'h4C);
        odg_host_model_inst.idle(1);
        cr = 1'b1;
        nr = 1'b1;
        cells.push_back({6'd0, 7'd16, 8'h1F});
        cells.push_back({6'd1, 7'd16, 8'h2E});
        cells.push_back({6'd0, 7'd17, 8'h3D});
        cells.push_back({6'd1, 7'd17, 8'h4C});
        wait_frame();
        check_cells();
    endtask
    task automatic t_start_line;
        cmd(8'hA0);
        cmd(8'h10);
        cmd(8'hA1);
        cmd(8'h38);
        odg_host_model_inst.idle(1);
        cr = 1'b0;
        nr = 1'b0;
        comr = 1'b1;
        sl = 6'h38;
        wait_frame();
        cmp_val({5'h0, pix[55][32]}, 13'd75, "row 0 on common 55");
        check_cells();
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        bad_count = 0;
        samples_checked = 0;
        step = 12;
        cr = 1'b0;
        nr = 1'b0;
        comr = 1'b0;
        sl = 6'h00;
        odg_host_model_inst.power_up();
        t_reset();
        t_contrast();
        t_power();
        t_window();
        t_period();
        t_vertical();
        t_start_line();
        // Second reset mid-run: settings must fall back, contrast included
        odg_host_model_inst.reset_again();
        t_reset();
        print_verdict();
    end
endmodule
